// ==== shared/ssee_map.vh ====
`ifndef SSEE_MAP_VH
`define SSEE_MAP_VH
// ==========================================
// Timing
`define SSEE_CLK_MHZ      100
`define SSEE_TWC_MS       5
`define SSEE_TWC_CYCLES   (`SSEE_TWC_MS * 1000 * `SSEE_CLK_MHZ)
`define SSEE_TWC_W        20
// ==========================================
// Serial framing and buffering
`define SSEE_BYTE_BITS    8
`define SSEE_BIT_CNT_W    3
`define SSEE_LAST_BIT     3'h7
`define SSEE_FIFO_DEPTH   16
// ==========================================
// Pin positions in the synchroniser vector
`define SSEE_PIN_N        5
`define SSEE_PIN_CS       0
`define SSEE_PIN_SCK      1
`define SSEE_PIN_SI       2
`define SSEE_PIN_HOLD     3
`define SSEE_PIN_WP       4
// Idle pin levels: select high, clock low, data low, pause high, protect high
`define SSEE_PIN_RST      5'h19
`endif

// ==== design/ssee_pin_ctrl.v ====
`timescale 1ns/100ps
`default_nettype none
`include "ssee_map.vh"

// ==========================================
// Received-byte FIFO with a registered output stage
module ssee_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = `SSEE_FIFO_DEPTH,
  parameter AW    = 4
) (
  input  wire             clk_in,
  input  wire             arst_n_in,
  input  wire             in_valid_in,
  output wire             in_ready_out,
  input  wire [WIDTH-1:0] in_data_in,
  output wire             out_valid_out,
  input  wire             out_ready_in,
  output wire [WIDTH-1:0] out_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  reg             out_valid_reg;
  reg [WIDTH-1:0] out_data_reg;
  wire            push;
  wire            pop;
  wire            full;
  wire            empty;

  // Honest full and empty from the entry count
  assign full          = (count_reg == DEPTH[AW:0]);
  assign empty         = (count_reg == {(AW+1){1'b0}});
  assign in_ready_out  = ~full;
  assign push          = in_valid_in & ~full;
  assign pop           = ~empty & (~out_valid_reg | out_ready_in);
  assign out_valid_out = out_valid_reg;
  assign out_data_out  = out_data_reg;

  // Storage array, write side
  always @(posedge clk_in) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data_in;
    end
  end

  // Pointers, count and output stage
  always @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wr_ptr_reg    <= {AW{1'b0}};
      rd_ptr_reg    <= {AW{1'b0}};
      count_reg     <= {(AW+1){1'b0}};
      out_valid_reg <= 1'b0;
      out_data_reg  <= {WIDTH{1'b0}};
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg   <= rd_ptr_reg + 1'b1;
        out_data_reg <= mem[rd_ptr_reg];
      end
      if (push & ~pop) begin
        count_reg <= count_reg + 1'b1;
      end else if (pop & ~push) begin
        count_reg <= count_reg - 1'b1;
      end
      if (pop) begin
        out_valid_reg <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule // ssee_fifo

// ==========================================
// Serial EEPROM pin control, device side
// What this block does
// - Select rising after a valid write sequence starts write cycle, 5 ms maximum.
// - Select low selects the device; select high deselects into standby.
// - A started write cycle completes; standby only after it ends.
// - Serial output released to high impedance whenever deselected.
// - No sequence accepted after power-up until select has been seen low.
// - Serial output changes only after a falling serial clock edge.
// - Serial input sampled at each rising serial clock edge.
// - Protect pin low with enable set refuses status writes only.
// - Protect pin low during a status-write sequence discards that write.
// - Protect pin falling during a running write cycle has no effect.
// - Enable cleared makes protect pin ignored; setting enable restores it.
// - Pause while selected suspends transfer, keeping sequence state for resume.
// - Pause lowered with clock high takes effect at next falling edge.
// - While paused, serial input and clock are ignored.
// - Pause raised with clock high resumes at next falling edge.
// - Output enable follows the pause pin directly, whatever the clock.
// - All bytes move most significant bit first.
module ssee_pin_ctrl #(
  parameter TWC_CYCLES = `SSEE_TWC_CYCLES,
  parameter TWC_W      = `SSEE_TWC_W,
  parameter FIFO_DEPTH = `SSEE_FIFO_DEPTH,
  parameter FIFO_AW    = 4
) (
  input  wire       ref_clk_in,
  input  wire       arst_n_in,
  input  wire       device_select_n_in,
  input  wire       serial_clk_in,
  input  wire       serial_data_in,
  input  wire       pause_n_in,
  input  wire       write_protect_n_in,
  output wire       serial_data_out,
  output wire       serial_data_oe_out,
  input  wire [7:0] tx_data_in,
  input  wire       read_mode_in,
  input  wire       write_seq_valid_in,
  input  wire       status_write_in,
  input  wire       protect_pin_enable_in,
  output wire [7:0] rx_data_out,
  output wire       rx_valid_out,
  input  wire       rx_ready_in,
  output wire       rx_overrun_out,
  output wire       tx_take_out,
  output wire       write_busy_out,
  output wire       write_start_out,
  output wire       write_done_out,
  output wire       status_refused_out,
  output wire       standby_out,
  output wire       selected_out,
  output wire       paused_out
);
  localparam [31:0]            TWC_M1   = TWC_CYCLES - 1;
  localparam [TWC_W-1:0]       TWC_LOAD = TWC_M1[TWC_W-1:0];
  localparam [`SSEE_PIN_N-1:0] PIN_RST  = `SSEE_PIN_RST;

  reg  [`SSEE_PIN_N-1:0]     sync1_reg;
  reg  [`SSEE_PIN_N-1:0]     sync2_reg;
  reg                        sck_d_reg;
  reg                        cs_d_reg;
  reg                        armed_reg;
  reg                        paused_reg;
  reg  [`SSEE_BIT_CNT_W-1:0] bit_cnt_reg;
  reg  [7:0]                 rx_shift_reg;
  reg                        got_byte_reg;
  reg                        pend_reg;
  reg  [7:0]                 pend_data_reg;
  reg                        overrun_reg;
  reg  [7:0]                 tx_shift_reg;
  reg                        so_reg;
  reg                        so_oe_reg;
  reg                        tx_take_reg;
  reg                        wp_low_seen_reg;
  reg                        busy_reg;
  reg  [TWC_W-1:0]           twc_cnt_reg;
  reg                        start_reg;
  reg                        done_reg;
  reg                        refused_reg;
  reg                        standby_reg;
  reg                        selected_reg;
  wire                       cs_n;
  wire                       sck;
  wire                       si;
  wire                       hold_n;
  wire                       wp_n;
  wire                       sck_rise;
  wire                       sck_fall;
  wire                       cs_rise;
  wire                       active;
  wire                       shift_ok;
  wire                       byte_done;
  wire                       fifo_ready;
  wire [7:0]                 rx_next;
  wire                       write_req;
  wire                       protect_hit;

  // ==========================================
  // Two-flop synchronisers for every pin
  genvar g;
  generate
    for (g = 0; g < `SSEE_PIN_N; g = g + 1) begin : g_sync
      always @(posedge ref_clk_in or negedge arst_n_in) begin
        if (!arst_n_in) begin
          sync1_reg[g] <= PIN_RST[g];
          sync2_reg[g] <= PIN_RST[g];
        end else begin
          sync1_reg[g] <= (g == `SSEE_PIN_CS)   ? device_select_n_in :
                          (g == `SSEE_PIN_SCK)  ? serial_clk_in :
                          (g == `SSEE_PIN_SI)   ? serial_data_in :
                          (g == `SSEE_PIN_HOLD) ? pause_n_in :
                                                  write_protect_n_in;
          sync2_reg[g] <= sync1_reg[g];
        end
      end
    end
  endgenerate

  assign cs_n   = sync2_reg[`SSEE_PIN_CS];
  assign sck    = sync2_reg[`SSEE_PIN_SCK];
  assign si     = sync2_reg[`SSEE_PIN_SI];
  assign hold_n = sync2_reg[`SSEE_PIN_HOLD];
  assign wp_n   = sync2_reg[`SSEE_PIN_WP];

  // ==========================================
  // Edge detection on synchronised levels
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sck_d_reg <= 1'b0;
      cs_d_reg  <= 1'b1;
    end else begin
      sck_d_reg <= sck;
      cs_d_reg  <= cs_n;
    end
  end

  assign sck_rise = sck & ~sck_d_reg;
  assign sck_fall = ~sck & sck_d_reg;
  assign cs_rise  = cs_n & ~cs_d_reg;
  assign active   = armed_reg & ~cs_n;
  assign shift_ok = active & ~paused_reg;
  assign byte_done = shift_ok & sck_rise & (bit_cnt_reg == `SSEE_LAST_BIT);
  assign rx_next  = {rx_shift_reg[6:0], si};

  // ==========================================
  // Power-up arming and pause state
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      armed_reg  <= 1'b0;
      paused_reg <= 1'b0;
    end else begin
      if (~cs_n) begin
        armed_reg <= 1'b1;
      end
      if (~active) begin
        paused_reg <= 1'b0;
      end else if (~sck | sck_fall) begin
        paused_reg <= ~hold_n;
      end
    end
  end

  // ==========================================
  // Receive shifter; bit count kept across a pause
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      bit_cnt_reg  <= {`SSEE_BIT_CNT_W{1'b0}};
      rx_shift_reg <= 8'h00;
      got_byte_reg <= 1'b0;
    end else if (~active) begin
      bit_cnt_reg  <= {`SSEE_BIT_CNT_W{1'b0}};
      if (~cs_n | cs_rise) begin
        got_byte_reg <= got_byte_reg;
      end else begin
        got_byte_reg <= 1'b0;
      end
    end else if (shift_ok & sck_rise) begin
      rx_shift_reg <= rx_next;
      bit_cnt_reg  <= bit_cnt_reg + 1'b1;
      if (bit_cnt_reg == `SSEE_LAST_BIT) begin
        got_byte_reg <= 1'b1;
      end
    end
  end

  // ==========================================
  // Completed byte held until the FIFO takes it
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      pend_reg      <= 1'b0;
      pend_data_reg <= 8'h00;
      overrun_reg   <= 1'b0;
    end else begin
      overrun_reg <= 1'b0;
      if (byte_done) begin
        if (pend_reg & ~fifo_ready) begin
          overrun_reg <= 1'b1;                              // Byte lost, FIFO full
        end else begin
          pend_reg      <= 1'b1;
          pend_data_reg <= rx_next;
        end
      end else if (fifo_ready) begin
        pend_reg <= 1'b0;
      end
    end
  end

  ssee_fifo #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (FIFO_AW)
  ) u_fifo (
    .clk_in        (ref_clk_in),
    .arst_n_in     (arst_n_in),
    .in_valid_in   (pend_reg),
    .in_ready_out  (fifo_ready),
    .in_data_in    (pend_data_reg),
    .out_valid_out (rx_valid_out),
    .out_ready_in  (rx_ready_in),
    .out_data_out  (rx_data_out)
  );

  // ==========================================
  // Transmit shifter, updated on falling clock only
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      tx_shift_reg <= 8'h00;
      so_reg       <= 1'b0;
      tx_take_reg  <= 1'b0;
    end else begin
      tx_take_reg <= 1'b0;
      if (shift_ok & sck_fall) begin
        if (bit_cnt_reg == {`SSEE_BIT_CNT_W{1'b0}}) begin
          so_reg       <= tx_data_in[7];
          tx_shift_reg <= {tx_data_in[6:0], 1'b0};
          tx_take_reg  <= 1'b1;
        end else begin
          so_reg       <= tx_shift_reg[7];
          tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
        end
      end
    end
  end

  // Output enable tracks select and the pause pin level
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      so_oe_reg <= 1'b0;
    end else begin
      so_oe_reg <= active & hold_n & read_mode_in;
    end
  end

  // ==========================================
  // Write protect tracking over one sequence
  assign write_req   = cs_rise & armed_reg & ~busy_reg & write_seq_valid_in &
                       got_byte_reg & (bit_cnt_reg == {`SSEE_BIT_CNT_W{1'b0}});
  assign protect_hit = status_write_in & protect_pin_enable_in &
                       (wp_low_seen_reg | ~wp_n);

  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      wp_low_seen_reg <= 1'b0;
    end else if (~active) begin
      wp_low_seen_reg <= 1'b0;
    end else if (~wp_n) begin
      wp_low_seen_reg <= 1'b1;
    end
  end

  // ==========================================
  // Self-timed write cycle; pins cannot cut it short
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_reg    <= 1'b0;
      twc_cnt_reg <= {TWC_W{1'b0}};
      start_reg   <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      start_reg   <= 1'b0;
      done_reg    <= 1'b0;
      refused_reg <= 1'b0;
      if (busy_reg) begin
        if (twc_cnt_reg == {TWC_W{1'b0}}) begin
          busy_reg <= 1'b0;
          done_reg <= 1'b1;
        end else begin
          twc_cnt_reg <= twc_cnt_reg - 1'b1;
        end
      end else if (write_req) begin
        if (protect_hit) begin
          refused_reg <= 1'b1;
        end else begin
          busy_reg    <= 1'b1;
          start_reg   <= 1'b1;
          twc_cnt_reg <= TWC_LOAD;
        end
      end
    end
  end

  // ==========================================
  // Standby and selection status
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      standby_reg  <= 1'b1;
      selected_reg <= 1'b0;
    end else begin
      standby_reg  <= cs_n & ~busy_reg;
      selected_reg <= active;
    end
  end

  assign serial_data_out    = so_reg;
  assign serial_data_oe_out = so_oe_reg;
  assign rx_overrun_out     = overrun_reg;
  assign tx_take_out        = tx_take_reg;
  assign write_busy_out     = busy_reg;
  assign write_start_out    = start_reg;
  assign write_done_out     = done_reg;
  assign status_refused_out = refused_reg;
  assign standby_out        = standby_reg;
  assign selected_out       = selected_reg;
  assign paused_out         = paused_reg;
endmodule // ssee_pin_ctrl
`default_nettype wire

// ==== test/ssee_pin_ctrl_monitor.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Pin control checker
module ssee_pin_ctrl_monitor #(parameter TWC_CYCLES = 50) (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic device_select_n_in,
  input wire logic serial_clk_in,
  input wire logic pause_n_in,
  input wire logic protect_pin_enable_in,
  input wire logic serial_data_out,
  input wire logic serial_data_oe_out,
  input wire logic write_busy_out,
  input wire logic write_start_out,
  input wire logic write_done_out,
  input wire logic status_refused_out,
  input wire logic standby_out,
  input wire logic selected_out,
  input wire logic paused_out
);
  int busy_cnt_reg;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!arst_n_in);
  // Busy cycles since the last start
  always @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) busy_cnt_reg <= 0;
    else if (write_start_out) busy_cnt_reg <= 0;
    else if (write_busy_out) busy_cnt_reg <= busy_cnt_reg + 1;
  end
  property p_start; write_start_out |-> ##[0:1] write_busy_out; endproperty
  a_start: assert property (p_start) else $error("no busy after start");
  property p_len;
    write_done_out |-> busy_cnt_reg == TWC_CYCLES - 1;
  endproperty
  a_len: assert property (p_len) else $error("write cycle length off");
  property p_idle; write_done_out |-> ##[0:1] !write_busy_out; endproperty
  a_idle: assert property (p_idle) else $error("busy after done");
  property p_stby; $past(write_busy_out) |-> !standby_out; endproperty
  a_stby: assert property (p_stby) else $error("standby while busy");
  property p_oe_dsel; standby_out |-> !serial_data_oe_out; endproperty
  a_oe_dsel: assert property (p_oe_dsel) else $error("output driven in standby");
  property p_sel; (!device_select_n_in) [*5] |-> selected_out; endproperty
  a_sel: assert property (p_sel) else $error("select not seen");
  property p_hold; $fell(pause_n_in) |-> ##[1:4] !serial_data_oe_out; endproperty
  a_hold: assert property (p_hold) else $error("output not released on pause");
  property p_pause;
    (!pause_n_in && !serial_clk_in && !device_select_n_in) [*4] |-> paused_out;
  endproperty
  a_pause: assert property (p_pause) else $error("pause not taken with clock low");
  property p_so;
    $changed(serial_data_out) |-> !$past(serial_clk_in, 3) || !$past(serial_clk_in, 4);
  endproperty
  a_so: assert property (p_so) else $error("output moved off falling edge");
  property p_ref;
    status_refused_out |-> !write_start_out && !write_busy_out && protect_pin_enable_in;
  endproperty
  a_ref: assert property (p_ref) else $error("bad refusal");
endmodule // ssee_pin_ctrl_monitor

bind ssee_pin_ctrl ssee_pin_ctrl_monitor #(.TWC_CYCLES(TWC_CYCLES)) u_mon (.ref_clk_in,
  .arst_n_in, .device_select_n_in, .serial_clk_in, .pause_n_in, .protect_pin_enable_in,
  .serial_data_out, .serial_data_oe_out, .write_busy_out, .write_start_out, .write_done_out,
  .status_refused_out, .standby_out, .selected_out, .paused_out);
`default_nettype wire

// ==== test/ssee_host_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ==========================================
// Host controller on the serial pins
module ssee_host_model (
  input  wire logic clk_in,
  input  wire logic so_in,
  output var  logic sel_n_out,
  output var  logic sck_out,
  output var  logic si_out,
  output var  logic pause_n_out
);
  // Idle levels, pause released
  initial begin
    sel_n_out = 1'b1;
    sck_out = 1'b0;
    si_out = 1'b0;
    pause_n_out = 1'b1;
  end
  // Half of a 160 ns serial period
  task automatic half();
    repeat (8) @(negedge clk_in);
  endtask
  // Select changes only with the clock low
  task automatic frame(input logic on);
    if (!on) half(); // Clock rests low before select rises
    sel_n_out <= !on;
    half();
  endtask
  // Bits MSB first; optional pause after bit pz with ignored clocks
  task automatic xfer(input logic [7:0] d, input int nb, input int pz, output logic [7:0] q);
    for (int i = 7; i > 7 - nb; i--) begin
      si_out <= d[i];
      half();
      sck_out <= 1'b1;
      q[i] = so_in;
      half();
      sck_out <= 1'b0;
      if (i == pz) begin
        pause_n_out <= 1'b0;
        half();
        repeat (4) begin
          sck_out <= ~sck_out;
          si_out <= ~si_out;
          half();
        end
        pause_n_out <= 1'b1;
        half();
      end
    end
  endtask
endmodule // ssee_host_model
`default_nettype wire

// ==== test/ssee_pin_ctrl_tb_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module ssee_pin_ctrl_tb_top;
  localparam int TWC = 400;
  localparam int PAUSE_CYC = 40; // Five half periods of the serial clock
  localparam logic [2:0] WCASE [4] = '{3'b010, 3'b110, 3'b100, 3'b111};
  logic ref_clk_in, arst_n_in, device_select_n_in, serial_clk_in, serial_data_in, pause_n_in;
  logic write_protect_n_in, serial_data_out, serial_data_oe_out, read_mode_in, rx_ready_in;
  logic write_seq_valid_in, status_write_in, protect_pin_enable_in, rx_valid_out, so_wire;
  logic rx_overrun_out, tx_take_out, write_busy_out, write_start_out, write_done_out;
  logic status_refused_out, standby_out, selected_out, paused_out, stall;
  logic [7:0] tx_data_in, rx_data_out, q;
  logic [7:0] exp_q [$];
  int failures = 0, tests_run = 0, cyc = 0, n_st = 0, n_rf = 0, n_dn = 0, n_ov = 0, es, er;
  int n_tk = 0, n_pz = 0;

  ssee_pin_ctrl #(.TWC_CYCLES(TWC)) DUT (.ref_clk_in, .arst_n_in, .device_select_n_in,
    .serial_clk_in, .serial_data_in, .pause_n_in, .write_protect_n_in, .serial_data_out,
    .serial_data_oe_out, .tx_data_in, .read_mode_in, .write_seq_valid_in, .status_write_in,
    .protect_pin_enable_in, .rx_data_out, .rx_valid_out, .rx_ready_in, .rx_overrun_out,
    .tx_take_out, .write_busy_out, .write_start_out, .write_done_out, .status_refused_out,
    .standby_out, .selected_out, .paused_out);
  ssee_host_model host (.clk_in(ref_clk_in), .so_in(so_wire), .sel_n_out(device_select_n_in),
    .sck_out(serial_clk_in), .si_out(serial_data_in), .pause_n_out(pause_n_in));
  // Released output shows no stale level
  assign so_wire = serial_data_oe_out ? serial_data_out : ~serial_data_out;

  // ==========================================
  // Clock, timeout, consumer readiness
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end
  always @(negedge ref_clk_in) begin
    rx_ready_in <= stall ? 1'b0 : 1'($urandom);
    cyc++;
    if (cyc > 20000) begin
      failures++;
      conclude();
    end
  end
  // Result watcher
  always @(posedge ref_clk_in) if (arst_n_in === 1'b1) begin
    if (rx_valid_out === 1'b1 && rx_ready_in === 1'b1)
      chk_byte("rx_data", exp_q.pop_front(), rx_data_out);
    n_st += int'(write_start_out === 1'b1);
    n_rf += int'(status_refused_out === 1'b1);
    n_dn += int'(write_done_out === 1'b1);
    n_ov += int'(rx_overrun_out === 1'b1);
    n_tk += int'(tx_take_out === 1'b1);
    n_pz += int'(paused_out === 1'b1);
  end

  // ==========================================
  // Compare and closing tasks
  task automatic chk_byte(string nm, logic [7:0] e, logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      failures++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic chk_cnt(string nm, int e, int g);
    tests_run++;
    if (g != e) begin
      failures++;
      $display("[ERR] %s exp %0d got %0d", nm, e, g);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // One frame of n random bytes, pause inside the second
  task automatic run(input int n, input int pz);
    logic [7:0] d;
    host.frame(1'b1);
    for (int b = 0; b < n; b++) begin
      d = 8'($urandom);
      if (b < 18) exp_q.push_back(d);
      host.xfer(d, 8, (b == 1) ? pz : -1, q);
    end
    host.frame(1'b0);
  endtask
  task automatic drain(string nm);
    stall = 1'b0;
    for (int i = 0; i < 600 && exp_q.size() > 0; i++) @(negedge ref_clk_in);
    chk_cnt("rx_left", 0, exp_q.size());
    $display("end of test %s", nm);
  endtask

  // ==========================================
  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    {tx_data_in, read_mode_in, write_seq_valid_in, status_write_in} = '0;
    {protect_pin_enable_in, stall, rx_ready_in, write_protect_n_in} = 4'h3;
    void'($urandom(93));
    repeat (6) @(negedge ref_clk_in);
    arst_n_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    // Read with pause: returned byte and received bytes
    read_mode_in = 1'b1;
    tx_data_in = 8'($urandom);
    run(4, 3);
    chk_byte("so_byte", tx_data_in, q);
    chk_cnt("tx_take", 4, n_tk);
    chk_cnt("paused_cycles", PAUSE_CYC, n_pz);
    drain("read_pause");
    // Fill receive buffer until a byte is lost
    read_mode_in = 1'b0;
    stall = 1'b1;
    run(19, -1);
    chk_cnt("overrun", 1, n_ov);
    drain("fill");
    // Write sequences under four protect and status-write combinations
    write_seq_valid_in = 1'b1;
    es = 0;
    er = 0;
    for (int k = 0; k < 4; k++) begin
      {status_write_in, protect_pin_enable_in, write_protect_n_in} = WCASE[k];
      run(1, -1);
      repeat (TWC + 20) @(negedge ref_clk_in);
      er += int'(WCASE[k] == 3'b110);
      es += int'(WCASE[k] != 3'b110);
      chk_cnt("starts", es, n_st);
      chk_cnt("refused", er, n_rf);
      chk_cnt("done", es, n_dn);
    end
    drain("protect");
    // Protect falls mid-cycle; write during busy; partial byte
    run(1, -1);
    repeat (10) @(negedge ref_clk_in);
    write_protect_n_in = 1'b0;
    run(1, -1);
    repeat (TWC) @(negedge ref_clk_in);
    write_protect_n_in = 1'b1;
    host.frame(1'b1);
    host.xfer(8'hA5, 4, -1, q);
    host.frame(1'b0);
    repeat (40) @(negedge ref_clk_in);
    chk_cnt("busy_starts", es + 1, n_st);
    chk_cnt("busy_done", es + 1, n_dn);
    chk_cnt("busy_refused", er, n_rf);
    drain("busy");
    conclude();
  end
endmodule // ssee_pin_ctrl_tb_top
`default_nettype wire
